/* hw/mbsc_pkg.sv */
// Purpose: Shared constants and types for the message buffer status/control bank
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
package mbsc_pkg;
    localparam int NUM_BUF = 59;
    localparam int DATA_WORDS = 16;
    localparam int AW = 12;
    // Register map
    localparam logic [11:0] OFF_CTRL_BASE = 12'h000;
    localparam logic [11:0] OFF_MODE = 12'h100;
    localparam logic [11:0] OFF_SEL = 12'h104;
    localparam logic [11:0] OFF_SLOT_STAT = 12'h108;
    localparam logic [11:0] OFF_MSG_ID = 12'h10c;
    localparam logic [11:0] OFF_NMV = 12'h110;
    localparam logic [11:0] OFF_FIFO_ACC = 12'h114;
    localparam logic [11:0] OFF_FIFO_REJ = 12'h118;
    localparam logic [11:0] OFF_FIFO_CNT = 12'h11c;
    localparam logic [11:0] OFF_FIFO_ACC_MASK = 12'h134;
    localparam logic [11:0] OFF_FIFO_REJ_MASK = 12'h138;
    localparam logic [11:0] OFF_DATA_BASE = 12'h200;
    // Control register bit positions
    localparam int B_USABLE = 15;
    localparam int B_TTYPE = 14;
    localparam int B_CYCF = 13;
    localparam int B_KIND = 12;
    localparam int B_DATA_UPDATED_BIT = 11;
    localparam int B_LINE2 = 10;
    localparam int B_LINE1 = 9;
    localparam int B_COMMIT = 8;
    localparam int B_HOLD = 6;
    localparam int B_IRQEN = 3;
    localparam int B_IRQPEND = 2;
    localparam int B_DIR = 0;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    // Writable masks per buffer configuration and state
    localparam logic [15:0] RX_ANY_MASK = 16'h0048;
    localparam logic [15:0] RX_CFG_MASK = 16'hae49;
    localparam logic [15:0] TX_ANY_MASK = 16'h4148;
    localparam logic [15:0] TX_CFG_MASK = 16'h7749;
    // Slot status positions
    localparam int S_VALID = 7;
    localparam int S_LINE = 8;
    // Filter word layout: [15:0] id, [21:16] cycle, [22] line
    localparam int F_CYC_LSB = 16;
    localparam int F_LINE = 22;

    typedef struct packed {
        logic valid;
        logic line;
        logic dynamic;
        logic preamble;
        logic [15:0] msg_id;
        logic [15:0] nm_vec;
        logic [5:0] cycle;
        logic [5:0] buf_idx;
        logic buf_hit;
    } mbsc_frame_t;

    typedef enum logic [1:0] {
        MBSC_CONFIG,
        MBSC_PASSIVE,
        MBSC_ACTIVE
    } mbsc_mode_t;
endpackage : mbsc_pkg

/* hw/mbsc_fifo_filter.sv */
// Purpose: Receive FIFO acceptance/rejection decision
// Assumes: Filter words hold id, cycle and line in package layout
// Notes: Combinational
`timescale 1ns/1ps
module mbsc_fifo_filter
(
    input wire mbsc_pkg::mbsc_frame_t frame,
    input wire logic [31:0] acc_val,
    input wire logic [31:0] acc_mask,
    input wire logic [31:0] rej_val,
    input wire logic [31:0] rej_mask,
    output logic accept
);
    logic [31:0] key;
    logic acc_hit;
    logic rej_hit;
    assign key = {9'h000, frame.line, frame.cycle, frame.msg_id};
    assign acc_hit = ((key ^ acc_val) & acc_mask) == 32'h0; // R4
    assign rej_hit = ((key ^ rej_val) & rej_mask) == 32'h0 && rej_mask != 32'h0;
    assign accept = frame.valid && acc_hit && !rej_hit && !frame.buf_hit; // R8 R9
endmodule : mbsc_fifo_filter

/* hw/mbsc_ctrl_word.sv */
// Purpose: Host write merge for one control word
// Assumes: Mode and direction decide writable bits
// Notes: Combinational
`timescale 1ns/1ps
module mbsc_ctrl_word
(
    input wire logic [15:0] cur,
    input wire logic [15:0] wdata,
    input wire logic in_config,
    output logic [15:0] merged
);
    logic [15:0] wmask;
    logic is_tx;
    assign is_tx = cur[mbsc_pkg::B_DIR]; // R16
    // R11 R15
    assign wmask = is_tx ? (in_config ? mbsc_pkg::TX_CFG_MASK : mbsc_pkg::TX_ANY_MASK)
                         : (in_config ? mbsc_pkg::RX_CFG_MASK : mbsc_pkg::RX_ANY_MASK);
    assign merged = (cur & ~wmask) | (wdata & wmask); // R18
endmodule : mbsc_ctrl_word

/* hw/mbsc_bank.sv */
// Purpose: Message buffer control/status bank with APB access
// Assumes: Protocol engine reports each slot as a one-cycle frame pulse
// Notes: Zero wait-state APB slave
// Notes on behaviour
// R1 - Valid flag set on correct frame
// R2 - Line flag: 0 first, 1 second
// R3 - Keep message id for dynamic preamble
// R4 - FIFO filter may compare message id
// R5 - Keep NM vector for static preamble
// R6 - Rx data stored only when filters pass
// R7 - Host loads tx payload data
// R8 - FIFO needs accept pass, reject miss
// R9 - Dedicated buffer beats the FIFO
// R10 - Control register per buffer 0..58
// R11 - Bit access depends on state, config
// R12 - Rx usable/updated writable only in config
// R13 - Hold, irq enable rw; pending device-set
// R14 - Dynamic tx type/commit rw; usable device-driven
// R15 - Config-only bits writable in config state
// R16 - Direction bit: 1 tx, 0 rx
// R17 - Pending set on rx; lock clears
// R18 - Read-only writes ignored; reserved read zero
`timescale 1ns/1ps
module mbsc_bank
#(
    parameter int NUM_BUF = mbsc_pkg::NUM_BUF,
    parameter int DATA_WORDS = mbsc_pkg::DATA_WORDS
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire mbsc_pkg::mbsc_frame_t frame,
    input wire logic [15:0] rx_payload [DATA_WORDS],
    input wire logic tx_done,
    input wire logic [5:0] tx_done_idx,
    output logic fifo_push,
    output logic [15:0] fifo_word0
);
    logic [15:0] ctrl [NUM_BUF];
    logic [15:0] data [NUM_BUF][DATA_WORDS];
    mbsc_pkg::mbsc_mode_t mode;
    logic [5:0] sel;
    logic [15:0] slot_stat [NUM_BUF];
    logic [15:0] msg_id [NUM_BUF];
    logic [15:0] nm_vec [NUM_BUF];
    logic [31:0] acc_val;
    logic [31:0] acc_mask;
    logic [31:0] rej_val;
    logic [31:0] rej_mask;
    logic [15:0] fifo_cnt;

    logic access;
    logic wr_en;
    logic rd_en;
    logic ctrl_hit;
    logic data_hit;
    logic [5:0] ctrl_idx;
    logic [3:0] data_idx;
    logic in_config;
    logic [15:0] merged;
    logic fifo_accept;
    logic rx_store;
    logic [15:0] next_stat;
    logic [31:0] next_rdata;
    logic map_hit;
    logic [5:0] fidx;

    function automatic logic idx_ok(input logic [5:0] idx);
        idx_ok = int'(idx) < NUM_BUF;
    endfunction : idx_ok

    assign access = psel && penable;
    assign wr_en = access && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign in_config = mode == mbsc_pkg::MBSC_CONFIG;
    assign ctrl_idx = paddr[7:2];
    assign ctrl_hit = paddr[11:8] == 4'h0 && idx_ok(ctrl_idx); // R10
    assign data_idx = paddr[5:2];
    assign data_hit = paddr[11:9] == 3'h1 && paddr[8:6] == 3'h0 && int'(data_idx) < DATA_WORDS;
    assign fidx = frame.buf_idx;
    assign rx_store = frame.valid && frame.buf_hit && idx_ok(fidx) && !ctrl[fidx][mbsc_pkg::B_DIR]; // R6
    assign next_stat = {7'h00, frame.line, frame.valid, 7'h00}; // R1 R2

    mbsc_ctrl_word u_word
    (
        .cur(ctrl[ctrl_idx]),
        .wdata(pwdata[15:0]),
        .in_config(in_config),
        .merged(merged)
    );

    mbsc_fifo_filter u_filt
    (
        .frame(frame),
        .acc_val(acc_val),
        .acc_mask(acc_mask),
        .rej_val(rej_val),
        .rej_mask(rej_mask),
        .accept(fifo_accept)
    );

    // Read mux
    always_comb
    begin
        next_rdata = 32'h0;
        map_hit = 1'b1;
        if (ctrl_hit)
            next_rdata = {16'h0, ctrl[ctrl_idx]};
        else if (data_hit)
            next_rdata = idx_ok(sel) ? {16'h0, data[sel][data_idx]} : 32'h0;
        else
            case (paddr)
                mbsc_pkg::OFF_MODE: next_rdata = {30'h0, mode};
                mbsc_pkg::OFF_SEL: next_rdata = {26'h0, sel};
                mbsc_pkg::OFF_SLOT_STAT: next_rdata = idx_ok(sel) ? {16'h0, slot_stat[sel]} : 32'h0;
                mbsc_pkg::OFF_MSG_ID: next_rdata = idx_ok(sel) ? {16'h0, msg_id[sel]} : 32'h0;
                mbsc_pkg::OFF_NMV: next_rdata = idx_ok(sel) ? {16'h0, nm_vec[sel]} : 32'h0;
                mbsc_pkg::OFF_FIFO_ACC: next_rdata = acc_val;
                mbsc_pkg::OFF_FIFO_REJ: next_rdata = rej_val;
                mbsc_pkg::OFF_FIFO_ACC_MASK: next_rdata = 32'h0;
                mbsc_pkg::OFF_FIFO_REJ_MASK: next_rdata = 32'h0;
                mbsc_pkg::OFF_FIFO_CNT: next_rdata = {16'h0, fifo_cnt};
                default: map_hit = 1'b0;
            endcase
    end

    // APB answer registers, zero wait
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !map_hit;
            if (rd_en)
                prdata <= next_rdata;
        end
    end

    // Global configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode <= mbsc_pkg::MBSC_CONFIG;
            sel <= 6'h00;
            acc_val <= 32'h0;
            acc_mask <= 32'h0;
            rej_val <= 32'h0;
            rej_mask <= 32'h0;
        end
        else if (wr_en)
        begin
            case (paddr)
                mbsc_pkg::OFF_MODE: mode <= mbsc_pkg::mbsc_mode_t'(pwdata[1:0]);
                mbsc_pkg::OFF_SEL: sel <= pwdata[5:0];
                mbsc_pkg::OFF_FIFO_ACC: acc_val <= pwdata;
                mbsc_pkg::OFF_FIFO_REJ: rej_val <= pwdata;
                mbsc_pkg::OFF_FIFO_ACC_MASK: acc_mask <= pwdata;
                mbsc_pkg::OFF_FIFO_REJ_MASK: rej_mask <= pwdata;
                default: ;
            endcase
        end
    end

    // Control words: host merge, then device updates; device update wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NUM_BUF; i++)
                ctrl[i] <= mbsc_pkg::CTRL_RESET; // R16 R13 R12
        end
        else
        begin
            if (wr_en && ctrl_hit)
            begin
                ctrl[ctrl_idx] <= merged; // R11 R12 R13 R14 R15 R18
                if (!ctrl[ctrl_idx][mbsc_pkg::B_DIR] && pwdata[mbsc_pkg::B_HOLD])
                    ctrl[ctrl_idx][mbsc_pkg::B_IRQPEND] <= 1'b0; // R17
            end
            if (rx_store)
            begin
                ctrl[fidx][mbsc_pkg::B_IRQPEND] <= 1'b1; // R17 R13
                ctrl[fidx][mbsc_pkg::B_DATA_UPDATED_BIT] <= 1'b1; // R12
                ctrl[fidx][mbsc_pkg::B_USABLE] <= 1'b1; // R12
            end
            if (tx_done && idx_ok(tx_done_idx) && ctrl[tx_done_idx][mbsc_pkg::B_DIR])
            begin
                ctrl[tx_done_idx][mbsc_pkg::B_USABLE] <= 1'b0; // R14
                ctrl[tx_done_idx][mbsc_pkg::B_COMMIT] <= 1'b0;
                ctrl[tx_done_idx][mbsc_pkg::B_IRQPEND] <= 1'b1; // R13
            end
        end
    end

    // Buffer contents
    always_ff @(posedge pclk)
    begin
        if (wr_en && data_hit && idx_ok(sel) && ctrl[sel][mbsc_pkg::B_DIR])
            data[sel][data_idx] <= pwdata[15:0]; // R7
        if (rx_store)
        begin
            for (int w = 0; w < DATA_WORDS; w++)
                data[fidx][w] <= rx_payload[w]; // R6
            if (frame.preamble && frame.dynamic)
                msg_id[fidx] <= frame.msg_id; // R3
            if (frame.preamble && !frame.dynamic)
                nm_vec[fidx] <= frame.nm_vec; // R5
        end
    end

    // Slot status of each slot report that hits a receive buffer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NUM_BUF; i++)
                slot_stat[i] <= 16'h0000;
        end
        else if (frame.buf_hit && idx_ok(fidx) && !ctrl[fidx][mbsc_pkg::B_DIR])
            slot_stat[fidx] <= next_stat; // R1 R2
    end

    // Receive FIFO push
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fifo_push <= 1'b0;
            fifo_word0 <= 16'h0;
            fifo_cnt <= 16'h0;
        end
        else
        begin
            fifo_push <= fifo_accept; // R8 R9
            if (fifo_accept)
            begin
                fifo_word0 <= rx_payload[0];
                fifo_cnt <= fifo_cnt + 16'h1;
            end
        end
    end
endmodule : mbsc_bank

/* testbench/mbsc_apb_host.sv */
// Purpose: Host model issuing APB transfers to the bank
// Assumes: One transfer at a time
// Notes: Released address and data show inverted values
`timescale 1ns/1ps
module mbsc_apb_host
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end
    // One APB read or write transfer; waits for pready, returns prdata and pslverr
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : mbsc_apb_host

/* testbench/mbsc_bank_asserts.sv */
// Purpose: Port checks for the buffer bank
// Assumes: Zero wait-state answer
// Notes: Bound to every bank instance
`timescale 1ns/1ps
module mbsc_bank_asserts
#(
    parameter int DATA_WORDS = 16
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire mbsc_pkg::mbsc_frame_t frame,
    input wire logic [15:0] rx_payload [DATA_WORDS],
    input wire logic fifo_push,
    input wire logic [15:0] fifo_word0
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        psel && penable && pready;
    endsequence
    chk_answer_after_setup: assert property (s_setup |=> s_answer) else $error("no answer after setup");
    chk_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
    chk_ready_in_access: assert property (pready |-> psel && penable) else $error("ready outside access");
    chk_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
    chk_err_unmapped: assert property (s_setup ##0 (paddr[11:10] != 2'b00) |=> pslverr) else $error("no error");
    chk_ctrl_mapped: assert property (s_setup ##0 (paddr < 12'h0ec) |=> !pslverr) else $error("ctrl refused");
    chk_push_no_hit: assert property (fifo_push |-> !$past(frame.buf_hit)) else $error("push despite hit");
    chk_push_word: assert property (fifo_push |-> fifo_word0 == $past(rx_payload[0])) else $error("bad word");
endmodule : mbsc_bank_asserts
bind mbsc_bank mbsc_bank_asserts #(.DATA_WORDS(DATA_WORDS)) u_mbsc_bank_asserts (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .frame(frame),
    .rx_payload(rx_payload), .fifo_push(fifo_push), .fifo_word0(fifo_word0));

/* testbench/tb_top.sv */
// Purpose: Self-checking bench for the buffer bank
// Assumes: Host model drives APB
// Notes: Expected words follow the writable masks
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_done, fifo_push, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] pl [16];
    logic [15:0] fifo_word0;
    logic [5:0] tx_done_idx;
    mbsc_pkg::mbsc_frame_t frame;
    int errors = 0;
    int n_compared = 0;
    mbsc_apb_host u_mbsc_apb_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    mbsc_bank u_mbsc_bank (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame(frame),
        .rx_payload(pl), .tx_done(tx_done), .tx_done_idx(tx_done_idx), .fifo_push(fifo_push),
        .fifo_word0(fifo_word0));
    task wr(input logic [11:0] a, input logic [31:0] d);
        u_mbsc_apb_host.xfer(1'b1, a, d, q, er);
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] e);
        u_mbsc_apb_host.xfer(1'b0, a, 32'h0, q, er);
        `CHK(q, e)
    endtask : rd
    task slot(input logic hit, input logic [5:0] idx, input logic [15:0] id, input logic [15:0] w0, input logic dyn,
        input logic ep);
        mbsc_pkg::mbsc_frame_t f;
        f = '{valid:1'b1, line:dyn, dynamic:dyn, preamble:1'b1, msg_id:id, nm_vec:id, buf_idx:idx, buf_hit:hit,
            default:'0};
        @(posedge pclk);
        frame <= f;
        pl[0] <= w0;
        @(posedge pclk);
        frame <= '0;
        #1;
        `CHK(fifo_push, ep)
        if (ep) `CHK(fifo_word0, w0)
    endtask : slot
    task test_done;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial
    begin
        #100us;
        errors++;
        test_done();
    end
    initial
    begin
        presetn = 1'b0;
        tx_done = 1'b0;
        tx_done_idx = 6'h00;
        frame = '0;
        foreach (pl[i]) pl[i] = 16'h0000;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h000, 32'h00000000);
        rd(12'h0e8, 32'h00000000);
        wr(12'h000, 32'h0000fffe);
        rd(12'h000, 32'h0000ae48);
        wr(12'h000, 32'h00002600);
        wr(12'h004, 32'h00000001);
        wr(12'h004, 32'h0000ffff);
        rd(12'h004, 32'h00007749);
        $display("config test done");
        wr(mbsc_pkg::OFF_MODE, 32'h00000002);
        wr(12'h000, 32'h00000000);
        rd(12'h000, 32'h00002600);
        wr(12'h004, 32'h00000000);
        rd(12'h004, 32'h00003601);
        $display("active access test done");
        slot(1'b1, 6'h00, 16'h1234, 16'hbeef, 1'b1, 1'b0);
        wr(mbsc_pkg::OFF_SEL, 32'h00000000);
        rd(mbsc_pkg::OFF_SLOT_STAT, 32'h00000180);
        rd(mbsc_pkg::OFF_MSG_ID, 32'h00001234);
        rd(mbsc_pkg::OFF_DATA_BASE, 32'h0000beef);
        rd(12'h000, 32'h0000ae04);
        wr(12'h000, 32'h00000040);
        rd(12'h000, 32'h0000ae40);
        slot(1'b1, 6'h00, 16'h4321, 16'hcafe, 1'b0, 1'b0);
        rd(mbsc_pkg::OFF_NMV, 32'h00004321);
        rd(mbsc_pkg::OFF_MSG_ID, 32'h00001234);
        rd(mbsc_pkg::OFF_SLOT_STAT, 32'h00000080);
        rd(mbsc_pkg::OFF_DATA_BASE, 32'h0000cafe);
        $display("receive test done");
        wr(mbsc_pkg::OFF_FIFO_ACC_MASK, 32'h00000000);
        `CHK(er, 1'b0)
        wr(mbsc_pkg::OFF_FIFO_REJ_MASK, 32'h00000000);
        slot(1'b0, 6'h05, 16'h0077, 16'h1357, 1'b1, 1'b1);
        wr(mbsc_pkg::OFF_FIFO_REJ, 32'h00000077);
        wr(mbsc_pkg::OFF_FIFO_REJ_MASK, 32'h0000ffff);
        slot(1'b0, 6'h05, 16'h0077, 16'h2468, 1'b1, 1'b0);
        wr(mbsc_pkg::OFF_FIFO_ACC, 32'h00000055);
        wr(mbsc_pkg::OFF_FIFO_ACC_MASK, 32'h0000ffff);
        slot(1'b0, 6'h05, 16'h0055, 16'h5555, 1'b1, 1'b1);
        slot(1'b0, 6'h05, 16'h0066, 16'h6666, 1'b1, 1'b0);
        rd(mbsc_pkg::OFF_FIFO_CNT, 32'h00000002);
        $display("fifo test done");
        wr(12'h004, 32'h00000100);
        rd(12'h004, 32'h00003701);
        @(posedge pclk);
        tx_done <= 1'b1;
        tx_done_idx <= 6'h01;
        @(posedge pclk);
        tx_done <= 1'b0;
        rd(12'h004, 32'h00003605);
        wr(mbsc_pkg::OFF_SEL, 32'h00000001);
        wr(mbsc_pkg::OFF_DATA_BASE, 32'h0000a5a5);
        rd(mbsc_pkg::OFF_DATA_BASE, 32'h0000a5a5);
        u_mbsc_apb_host.xfer(1'b0, 12'hffc, 32'h0, q, er);
        `CHK(er, 1'b1)
        $display("transmit test done");
        test_done();
    end
endmodule : tb_top
